// *** include/dacctl_defines.svh ***
// Purpose: Constants for the converter control block.
// Assumes: Byte offsets on a 32-bit classic Wishbone bus.
// Notes: Printed offsets 0x00 and 0x01 are indices; byte address is 4x.
`ifndef DACCTL_DEFINES_SVH
`define DACCTL_DEFINES_SVH
`define DACCTL_IDX_CTRL 4'h0
`define DACCTL_IDX_DATA 4'h1
`define DACCTL_IDX_SLEEP 4'h2
`define DACCTL_IDX_STAT 4'h3
`define DACCTL_BIT_ENABLE 0
`define DACCTL_BIT_PINBUF 6
`define DACCTL_BIT_RUNSTBY 7
`define DACCTL_CTRL_RST 8'h00
`define DACCTL_DATA_RST 8'h00
`define DACCTL_SLEEP_RST 2'h0
`define DACCTL_CTRL_MASK 8'hC1
`define DACCTL_INSTANCE 0
`endif

// *** include/dacctl_pkg.sv ***
// Purpose: Types for the converter control block.
// Assumes: Nothing beyond the defines header.
// Notes: Sleep mode encoding is shared with the register file.
package dacctl_pkg;
  typedef enum logic [1:0] {
    DACCTL_ACTIVE = 2'h0,
    DACCTL_IDLE = 2'h1,
    DACCTL_STANDBY = 2'h2,
    DACCTL_PWRDOWN = 2'h3
  } dacctl_sleep_t;
  typedef enum logic [2:0] {
    DACCTL_S_OFF = 3'b001,
    DACCTL_S_ON = 3'b010,
    DACCTL_S_HALT = 3'b100
  } dacctl_state_t;
endpackage

// *** include/dacctl_reg_if.sv ***
// Purpose: Carrier between the bus front end and the control core.
// Assumes: One clock domain.
// Notes: Write strobes are one-cycle pulses.
`timescale 1ns/1ps
interface dacctl_reg_if;
  logic ctrl_we;
  logic data_we;
  logic sleep_we;
  logic [7:0] wdata;
  logic [7:0] ctrl_q;
  logic [7:0] data_q;
  logic [1:0] sleep_q;
  modport bus (output ctrl_we, data_we, sleep_we, wdata,
    input ctrl_q, data_q, sleep_q);
  modport core (input ctrl_we, data_we, sleep_we, wdata,
    output ctrl_q, data_q, sleep_q);
endinterface

// *** rtl/dacctl_regs.sv ***
// Purpose: Control and data register storage.
// Assumes: Strobes come from the Wishbone front end.
// Notes: Only defined control bits are stored; others read zero.
`timescale 1ns/1ps
`include "dacctl_defines.svh"
module dacctl_regs (
  input wire logic clk,
  input wire logic rst,
  dacctl_reg_if.core rif
);
  import dacctl_pkg::*;
  logic [7:0] ctrl_r;
  logic [7:0] data_r;
  logic [1:0] sleep_r;

  // Control register keeps enable, pin buffer and standby bits.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= `DACCTL_CTRL_RST;
    end else if (rif.ctrl_we) begin
      ctrl_r <= rif.wdata & `DACCTL_CTRL_MASK;
    end
  end

  // Data register stores the value whether enabled or not.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_r <= `DACCTL_DATA_RST;
    end else if (rif.data_we) begin
      data_r <= rif.wdata;
    end
  end

  // Sleep mode request as seen by the power controller.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sleep_r <= `DACCTL_SLEEP_RST;
    end else if (rif.sleep_we) begin
      sleep_r <= rif.wdata[1:0];
    end
  end

  assign rif.ctrl_q = ctrl_r;
  assign rif.data_q = data_r;
  assign rif.sleep_q = sleep_r;
endmodule

// *** rtl/dacctl_top.sv ***
// Purpose: Conversion control for an 8-bit resistor-string converter.
// Assumes: Classic Wishbone slave, 32-bit data, one clock at 40 MHz.
// Notes: Analog core is outside; this block drives its controls.
// Notes: Writes land at the taking edge; ack follows one cycle later.
// Notes: Sleep mode comes from a register standing in for the system.
// Notes: Debug halt is synchronised and shown in status, never acted on.
// Notes: Instance parameter other than zero removes the pin buffer.
// Function
// - Enable bit written one enables, written zero disables converter.
// - Data write while enabled starts a conversion at once.
// - Data write while disabled only stores; enabling later converts.
// - Output reaches the pin only with the pin buffer enable set.
// - Enabled converter feeds comparator and ADC regardless of pin buffer.
// - Standby with run-in-standby set keeps the converter running.
// - Standby without run-in-standby powers down converter and buffer.
// - Leaving standby re-enables converter; buffer only if pin enable set.
// - Power-down sleep always disables converter and buffer.
// - An 8-bit value maps linearly from ground to reference.
// - Only instance zero has a pin output driver.
// - Debug halt does not change converter behaviour.
// - Control register at 0x00 holds enable in bit 0, resets zero.
// - Control bit 6 enables the pin output buffer.
// - Control bit 7 keeps converter on through standby entry.
// - Data register at 0x01, 8 bits, read and write, resets zero.
//
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "dacctl_defines.svh"
module dacctl_top #(
  parameter int INSTANCE = `DACCTL_INSTANCE
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic DEBUG_HALT,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic WB_ERR_O,
  output logic [7:0] CONV_DATA,
  output logic CONV_START,
  output logic CORE_POWER,
  output logic PIN_BUFFER_POWER,
  output logic INTERNAL_OUT_VALID
);
  import dacctl_pkg::*;

  // Carrier to the register storage; strobes go out, stored values return.
  dacctl_reg_if rif ();

  // Bus front end.
  logic req;
  logic [3:0] idx;
  logic aligned;
  logic ack_r;
  logic err_r;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic ctrl_we;
  logic data_we;
  logic sleep_we;
  // Control core.
  logic [1:0] dbg_sync_r;
  dacctl_state_t state_r;
  dacctl_state_t state_nxt;
  logic run_ok;
  logic start_r;
  logic core_r;
  logic buf_r;
  logic [7:0] conv_r;
  logic was_en;
  logic mapped;
  logic ack_nxt;
  logic err_nxt;
  logic start_nxt;
  logic core_nxt;
  logic buf_nxt;
  logic [7:0] conv_nxt;

  // Maps a byte address to a register index; upper bits must be zero.
  function automatic logic [3:0] word_index(input logic [31:0] a);
    word_index = a[5:2];
  endfunction

  // True for a word-aligned address inside the four-register window.
  // Anything else is answered with err and has no effect.
  function automatic logic addr_mapped(input logic [31:0] a);
    addr_mapped = (a[1:0] == 2'h0) && (a[31:6] == 26'h0) &&
      (a[5:2] <= `DACCTL_IDX_STAT);
  endfunction

  // True when the control state lets the analog core run.
  // Used for the present and the next state alike.
  function automatic logic is_run(input dacctl_state_t s);
    is_run = (s == DACCTL_S_ON);
  endfunction

  // Status word: running, core power, pin buffer power, halt seen.
  // Bits above the fourth read zero.
  function automatic logic [31:0] status_word(input logic run,
      input logic core, input logic pin, input logic halt);
    status_word = {28'h0, halt, pin, core, run};
  endfunction

  // A request is taken once; the answer flop masks it for the next edge.
  // Without that mask a held request would be answered twice.
  assign req = WB_CYC_I && WB_STB_I && !ack_r && !err_r;
  assign idx = word_index(WB_ADR_I);
  assign aligned = (WB_ADR_I[1:0] == 2'h0) && (WB_ADR_I[31:6] == 26'h0);
  assign mapped = addr_mapped(WB_ADR_I);

  // Write strobes need byte lane 0, where all register data sits.
  // A write without lane 0 is still acked but stores nothing.
  always_comb begin
    ctrl_we = 1'b0;
    data_we = 1'b0;
    sleep_we = 1'b0;
    if (req && WB_WE_I && aligned && WB_SEL_I[0]) begin
      if (idx == `DACCTL_IDX_CTRL) begin
        ctrl_we = 1'b1;
      end else if (idx == `DACCTL_IDX_DATA) begin
        data_we = 1'b1;
      end else if (idx == `DACCTL_IDX_SLEEP) begin
        sleep_we = 1'b1;
      end
    end
  end

  // Strobes and write data handed to the register storage.
  assign rif.ctrl_we = ctrl_we;
  assign rif.data_we = data_we;
  assign rif.sleep_we = sleep_we;
  assign rif.wdata = WB_DAT_I[7:0];

  // Storage sits in its own module so this decode stays small.
  dacctl_regs u_regs (
    .clk(SYS_CLK),
    .rst(RST),
    .rif(rif)
  );

  // Read mux; the status word shows the live state of the control core.
  // Unmapped indices read zero; the err answer covers them anyway.
  always_comb begin
    rdat_nxt = 32'h0;
    if (idx == `DACCTL_IDX_CTRL) begin
      rdat_nxt = {24'h0, rif.ctrl_q};
    end else if (idx == `DACCTL_IDX_DATA) begin
      rdat_nxt = {24'h0, rif.data_q};
    end else if (idx == `DACCTL_IDX_SLEEP) begin
      rdat_nxt = {30'h0, rif.sleep_q};
    end else if (idx == `DACCTL_IDX_STAT) begin
      rdat_nxt = status_word(was_en, core_r, buf_r, dbg_sync_r[1]);
    end
  end

  // Answer decode: a taken request gets exactly one of ack or err.
  // Unmapped or misaligned accesses answer with err and change nothing.
  always_comb begin
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    if (req) begin
      if (mapped) begin
        ack_nxt = 1'b1;
      end else begin
        err_nxt = 1'b1;
      end
    end
  end

  // Ack stands for one cycle because the taken request masks itself.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  // Err follows the same one-cycle timing as ack.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      err_r <= 1'b0;
    end else begin
      err_r <= err_nxt;
    end
  end

  // Read data are registered each cycle; the master takes them with ack.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      rdat_r <= 32'h0;
    end else begin
      rdat_r <= rdat_nxt;
    end
  end

  // The halt pin is only synchronised; it is deliberately not acted on.
  // Its second stage feeds the status word so software can see halt.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      dbg_sync_r <= 2'h0;
    end else begin
      dbg_sync_r <= {dbg_sync_r[0], DEBUG_HALT};
    end
  end

  // Sleep gating: standby stops only without run-in-standby.
  always_comb begin
    run_ok = 1'b1;
    if (rif.sleep_q == DACCTL_PWRDOWN) begin
      run_ok = 1'b0;
    end else if (rif.sleep_q == DACCTL_STANDBY) begin
      run_ok = rif.ctrl_q[`DACCTL_BIT_RUNSTBY];
    end else if (rif.sleep_q == DACCTL_IDLE) begin
      run_ok = 1'b1; // Idle sleep leaves peripherals running.
    end else if (rif.sleep_q == DACCTL_ACTIVE) begin
      run_ok = 1'b1;
    end
  end

  // State machine: off, running, or parked by sleep.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // Off: waits for the enable bit.
      DACCTL_S_OFF: begin
        if (rif.ctrl_q[`DACCTL_BIT_ENABLE]) begin
          state_nxt = run_ok ? DACCTL_S_ON : DACCTL_S_HALT;
        end
      end
      // Running: leaves on disable or when sleep stops the core.
      DACCTL_S_ON: begin
        if (!rif.ctrl_q[`DACCTL_BIT_ENABLE]) begin
          state_nxt = DACCTL_S_OFF;
        end else if (!run_ok) begin
          state_nxt = DACCTL_S_HALT;
        end
      end
      // Parked by sleep: resumes when sleep allows running again.
      DACCTL_S_HALT: begin
        if (!rif.ctrl_q[`DACCTL_BIT_ENABLE]) begin
          state_nxt = DACCTL_S_OFF;
        end else if (run_ok) begin
          state_nxt = DACCTL_S_ON;
        end
      end
      default: begin
        state_nxt = DACCTL_S_OFF;
      end
    endcase
  end

  // State register.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_r <= DACCTL_S_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // The core was running in the cycle now ending.
  assign was_en = is_run(state_r);

  // Power and start are decided from the next state so that the start
  // pulse and the power it needs rise together.
  always_comb begin
    start_nxt = 1'b0;
    core_nxt = 1'b0;
    buf_nxt = 1'b0;
    if (is_run(state_nxt)) begin
      core_nxt = 1'b1;
      if (!was_en || data_we) begin
        start_nxt = 1'b1;
      end
      if ((INSTANCE == 0) && rif.ctrl_q[`DACCTL_BIT_PINBUF]) begin
        buf_nxt = 1'b1;
      end
    end
  end

  // Code for the core: the bus value when it is written in the same
  // cycle, so a start never converts a value that has not landed.
  always_comb begin
    conv_nxt = conv_r;
    if (is_run(state_nxt)) begin
      if (data_we) begin
        conv_nxt = WB_DAT_I[7:0];
      end else begin
        conv_nxt = rif.data_q;
      end
    end
  end

  // Start pulse register; high for one cycle per conversion.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      start_r <= 1'b0;
    end else begin
      start_r <= start_nxt;
    end
  end

  // Code register presented to the core.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      conv_r <= 8'h00;
    end else begin
      conv_r <= conv_nxt;
    end
  end

  // Core power; the internal output is valid exactly while it is on.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      core_r <= 1'b0;
    end else begin
      core_r <= core_nxt;
    end
  end

  // Pin buffer power; only instance zero ever drives it high.
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      buf_r <= 1'b0;
    end else begin
      buf_r <= buf_nxt;
    end
  end

  // No interrupt or event port exists on this block.
  assign WB_ACK_O = ack_r;
  assign WB_ERR_O = err_r;
  assign WB_DAT_O = rdat_r;

  // Core controls, each straight from a flop; internal valid shares the core power flop.
  assign CONV_DATA = conv_r;
  assign CONV_START = start_r;
  assign CORE_POWER = core_r;
  assign PIN_BUFFER_POWER = buf_r;
  assign INTERNAL_OUT_VALID = core_r;
endmodule

// *** tb/dacctl_properties.sv ***
// Purpose: Port checks for the converter control block.
// Assumes: One clock, reset asynchronous and active high.
// Notes: Bound to the top module from the bench file.
`timescale 1ns/1ps
module dacctl_properties (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic WB_ERR_O,
  input wire logic [7:0] CONV_DATA,
  input wire logic CONV_START,
  input wire logic CORE_POWER,
  input wire logic PIN_BUFFER_POWER,
  input wire logic INTERNAL_OUT_VALID
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // A request counts once, while no answer is outstanding.
  sequence taken_s;
    WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O;
  endsequence
  sequence data_wr_s;
    taken_s ##0 (WB_WE_I && WB_ADR_I == 32'h4 && WB_SEL_I[0]);
  endsequence
  answer_once_a: assert property (taken_s |=> WB_ACK_O ^ WB_ERR_O)
    else $error("request not answered once");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  misalign_err_a: assert property (taken_s ##0 WB_ADR_I[1:0] != 2'h0
    |=> WB_ERR_O) else $error("misaligned access not refused");
  read_upper_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  data_start_a: assert property (data_wr_s ##0 CORE_POWER |=>
    CONV_START && CONV_DATA == $past(WB_DAT_I[7:0]))
    else $error("data write did not start conversion");
  start_pulse_a: assert property (CONV_START |=> !CONV_START)
    else $error("start longer than one cycle");
  start_power_a: assert property (CONV_START |-> CORE_POWER)
    else $error("start while converter off");
  pin_power_a: assert property (PIN_BUFFER_POWER |-> CORE_POWER)
    else $error("pin buffer on without converter");
  internal_out_a: assert property (INTERNAL_OUT_VALID == CORE_POWER)
    else $error("internal output differs from power");
endmodule

// *** tb/dacctl_core_model.sv ***
// Purpose: Behavioural analog core beside the control block.
// Assumes: Starts are one-cycle pulses on the block clock.
// Notes: Holds the last code taken and counts the starts.
`timescale 1ns/1ps
module dacctl_core_model (
  input wire logic clk,
  input wire logic [7:0] code,
  input wire logic start,
  input wire logic power,
  output logic [7:0] out_level,
  output int starts
);
  logic [7:0] held;
  initial starts = 0;
  // Each start latches one code for a linear output level.
  always @(posedge clk) begin
    if (start) begin
      held <= code;
      starts <= starts + 1;
    end
  end
  // An unpowered core shows ground, not its stale code.
  assign out_level = power ? held : 8'h00;
endmodule

// *** tb/dacctl_conversion_control_bench.sv ***
// Purpose: Self-checking bench for the converter control block.
// Assumes: Wishbone answer one cycle after the taking edge.
// Notes: Sleep register stands in for the system sleep controller.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
  err_total++; $display("mismatch t=%0t got=%h exp=%h", $time, a, e); \
  end end
module dac_conversion_control_bench;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic halt = 1'b0, ack, eo, e, start, pwr, pin, ivld;
  logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, q;
  logic [3:0] sel = 4'hF;
  logic [7:0] cdat, lvl;
  int starts, s0, err_total = 0, check_count = 0, cyc_n = 0;
  dacctl_top u_dacctl_top (.SYS_CLK(clk), .RST(rst), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .DEBUG_HALT(halt), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .WB_ERR_O(eo), .CONV_DATA(cdat), .CONV_START(start), .CORE_POWER(pwr),
    .PIN_BUFFER_POWER(pin), .INTERNAL_OUT_VALID(ivld));
  dacctl_core_model u_dacctl_core_model (.clk(clk), .code(cdat),
    .start(start), .power(pwr), .out_level(lvl), .starts(starts));
  // One classic cycle; the request holds until ack or err is sampled.
  task automatic wb(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk); while (!(ack || eo) && ++n < 20);
    if (n >= 20) err_total++;
    q = rdat;
    e = eo;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] x);
    wb(1'b0, a, 32'h0);
    `CHK(q, {24'h0, x})
  endtask
  task automatic w3;
    repeat (3) @(posedge clk);
  endtask
  task automatic outs(input logic p, b);
    `CHK(pwr, p)
    `CHK(pin, b)
    `CHK(ivld, p)
  endtask
  task automatic t_reset;
    rd(32'h0, 8'h00);
    rd(32'h4, 8'h00);
    outs(1'b0, 1'b0);
  endtask
  task automatic t_store;
    s0 = starts;
    wb(1'b1, 32'h4, 32'h5A); w3();
    `CHK(starts - s0, 0)
    wb(1'b1, 32'h0, 32'h01); w3();
    `CHK(starts - s0, 1)
    `CHK(lvl, 8'h5A)
    outs(1'b1, 1'b0);
  endtask
  task automatic t_run;
    s0 = starts;
    wb(1'b1, 32'h4, 32'h00);
    wb(1'b1, 32'h4, 32'hFF); w3();
    `CHK(starts - s0, 2)
    `CHK(lvl, 8'hFF)
    wb(1'b1, 32'h0, 32'hFF);
    rd(32'h0, 8'hC1);
    outs(1'b1, 1'b1);
    rd(32'hC, 8'h07);
    sel <= 4'hE;
    wb(1'b1, 32'h4, 32'h11);
    sel <= 4'hF;
    rd(32'h4, 8'hFF);
  endtask
  task automatic t_sleep;
    wb(1'b1, 32'h0, 32'h41);
    wb(1'b1, 32'h8, 32'h2); w3();
    outs(1'b0, 1'b0);
    wb(1'b1, 32'h8, 32'h0); w3();
    outs(1'b1, 1'b1);
    wb(1'b1, 32'h0, 32'hC1);
    wb(1'b1, 32'h8, 32'h2); w3();
    outs(1'b1, 1'b1);
    wb(1'b1, 32'h8, 32'h3); w3();
    rd(32'h8, 8'h03);
    outs(1'b0, 1'b0);
    wb(1'b1, 32'h8, 32'h0); w3();
  endtask
  task automatic t_halt_err;
    halt <= 1'b1;
    s0 = starts;
    wb(1'b1, 32'h4, 32'h33); w3();
    `CHK(starts - s0, 1)
    rd(32'hC, 8'h0F);
    halt <= 1'b0;
    wb(1'b1, 32'h10, 32'h0);
    `CHK(e, 1'b1)
    wb(1'b0, 32'h1, 32'h0);
    `CHK(e, 1'b1)
    wb(1'b1, 32'h0, 32'h0); w3();
    outs(1'b0, 1'b0);
  endtask
  task automatic stop_test;
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Clock at 40 MHz; a hang ends at a cycle ceiling.
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (++cyc_n == 5000) begin
    err_total++;
    stop_test();
  end
  // Reset for three cycles, then the scenarios in turn.
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_store();
    t_run();
    t_sleep();
    t_halt_err();
    stop_test();
  end
endmodule
bind dacctl_top dacctl_properties u_dacctl_properties (.*);
